//--- verification/cmb_bus_node.sv
// far bus node seen through its transceiver
`timescale 1ns/10ps
`default_nettype none
module cmb_bus_node (
	input	wire logic	ref_clk,
	input	wire logic	bus_tx_pin,
	input	wire logic	node_dom,
	output	var logic	bus_rx_pin
);
	// wired bus: dominant zero wins
	always_ff @(posedge ref_clk) bus_rx_pin <= bus_tx_pin & ~node_dom;
endmodule // cmb_bus_node
`default_nettype wire

//--- verification/cmb_message_buffer_filter_assertions.sv
// port checks for the message buffer and filter
`timescale 1ns/10ps
`default_nettype none
module cmb_mbf_assertions (
	input	wire logic			ref_clk,
	input	wire logic			reset,
	input	wire logic			avs_read,
	input	wire logic			avs_write,
	input	wire logic [31:0]		avs_readdata,
	input	wire logic			avs_waitrequest,
	input	wire cmb_pkg::cmb_eng_in_s	eng_in,
	input	wire cmb_pkg::cmb_eng_out_s	eng_out,
	input	wire logic			bus_tx_pin,
	input	wire logic			rx_irq,
	input	wire logic			tx_irq,
	input	wire logic			err_irq
);
	import cmb_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_wait_one_pulse: assert property (
		avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not a one-cycle answer");
	a_write_reads_zero: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("write answer carries data");
	a_pin_dominant_cause: assert property (!bus_tx_pin |-> !$past(eng_in.tx_bit))
		else $error("pin dominant without engine request");
	a_rx_irq_cause: assert property (
		$rose(rx_irq) |-> $past(eng_in.rx_ok) || $past(eng_in.rx_ok, 2) || $past(avs_write, 2))
		else $error("receive interrupt without cause");
	a_ovr_irq_cause: assert property (
		$rose(err_irq) |-> $past(eng_in.rx_ok) || $past(eng_in.rx_ok, 2) || $past(avs_write, 2))
		else $error("overrun interrupt without cause");
	a_ack_own_frame: assert property (
		$fell(eng_out.ack_en) |-> $past(eng_in.arb_req) || $past(eng_in.arb_req, 2))
		else $error("acknowledge dropped outside own frame");
	a_tx_irq_cause: assert property ($rose(tx_irq) |->
		$past(eng_in.tx_done) || $past(eng_in.tx_done, 2) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("transmit interrupt without cause");
	a_sel_in_range: assert property (eng_out.tx_valid |-> eng_out.tx_sel != 2'h3)
		else $error("selected buffer out of range");
endmodule // cmb_mbf_assertions
bind cmb_message_buffer_filter cmb_mbf_assertions cmb_mbf_assertions_i (.ref_clk(ref_clk), .reset(reset),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.eng_in(eng_in), .eng_out(eng_out), .bus_tx_pin(bus_tx_pin), .rx_irq(rx_irq), .tx_irq(tx_irq),
	.err_irq(err_irq));
`default_nettype wire

//--- verification/tb_cmb_message_buffer_filter.sv
// self-checking bench for the message buffer and filter
`timescale 1ns/10ps
`default_nettype none
module tb_cmb_message_buffer_filter;
	import cmb_pkg::*;
	localparam int OK = 9, ARB = 8, DONE = 7, LOST = 6, ERR = 5;
	logic		ref_clk, reset, avs_read, avs_write, node_dom, bus_rx_pin, bus_tx_pin, wreq;
	logic		rx_irq, tx_irq, err_irq, t, pv;
	logic [9:0]	avs_address;
	logic [31:0]	avs_writedata, rdata, q, id, p, k;
	logic [7:0]	pr [3];
	logic [2:0]	a;
	logic [39:0]	th, dh;
	logic [1:0]	best;
	cmb_eng_in_s	ei;
	cmb_eng_out_s	eo;
	int		error_cnt = 0, check_count = 0, cyc = 0;
	cmb_message_buffer_filter cmb_message_buffer_filter_i (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq), .eng_in(ei), .eng_out(eo),
		.bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .rx_irq(rx_irq), .tx_irq(tx_irq), .err_irq(err_irq));
	cmb_bus_node cmb_bus_node_i (.ref_clk(ref_clk), .bus_tx_pin(bus_tx_pin), .node_dom(node_dom),
		.bus_rx_pin(bus_rx_pin));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] ad, input logic [31:0] d);
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// waitrequest low ends this wait, the bench timeout ends one that hangs
		do begin
			@(posedge ref_clk);
		end while (wreq !== 1'b0);
		q = rdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [9:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h0);
		chk(q, e);
	endtask
	task automatic pl(input int b);
		ei[b] <= 1'b1;
		@(posedge ref_clk);
		ei[b] <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic fr(input logic [31:0] fid, input logic [7:0] d);
		for (int j = 0; j < 13; j++) begin
			ei.rx_we <= 1'b1;
			ei.rx_idx <= 4'(j);
			ei.rx_data <= j < 4 ? fid[8*j+:8] : d + 8'(j);
			@(posedge ref_clk);
		end
		ei.rx_we <= 1'b0;
		pl(OK);
	endtask
	// accept bit and hit index for mode, identifier, pattern, mask
	function automatic logic [2:0] acc(logic [1:0] m, logic [31:0] fid, logic [31:0] fp, logic [31:0] fk);
		logic [3:0] e;
		int s;
		for (int b = 0; b < 4; b++) begin
			s = m == 2'h1 ? b % 2 : m == 2'h2 ? 0 : b;
			e[b] = ((fid[8*s+:8] ^ fp[8*b+:8]) & ~fk[8*b+:8]) == 8'h0;
		end
		case (m)
			2'h0: return {e == 4'hf, 2'h0};
			2'h1: return {e[1:0] == 2'h3 || e[3:2] == 2'h3, e[1:0] == 2'h3 ? 2'h0 : 2'h1};
			2'h2: return {e != 4'h0, e[0] ? 2'h0 : e[1] ? 2'h1 : e[2] ? 2'h2 : 2'h3};
			default: return 3'h0;
		endcase
	endfunction
	initial begin
		reset <= 1'b1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= 10'h0;
		avs_writedata <= 32'h0;
		ei <= cmb_eng_in_s'(1);
		node_dom <= 1'b0;
		void'($urandom(32'hf9df));
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_TXFLAG, 32'(RST_TX_EMPTY));
		rd(10'h3fc, 32'h0);
		for (int i = 0; i < 24; i++) begin
			id = $urandom;
			p = id ^ ($urandom & $urandom & $urandom);
			k = i < 4 ? 32'hffffffff : $urandom & $urandom;
			bus(1'b1, OFS_CTRL, 32'(i % 4) << CTRL_MODE_LSB);
			bus(1'b1, OFS_PATTERN, p);
			bus(1'b1, OFS_MASK, k);
			a = acc(2'(i % 4), id, p, k);
			fr(id, 8'(i));
			rd(OFS_RXFLAG, 32'(a[2]));
			if (a[2]) begin
				rd(OFS_HIT, 32'(a[1:0]));
				rd(10'h070, 32'(8'(i + 12)));
				bus(1'b1, OFS_RXFLAG, 32'h1);
			end
			rd(OFS_RXFLAG, 32'h0);
		end
		bus(1'b1, OFS_CTRL, 32'h0);
		// open filter so the random identifiers below are accepted
		bus(1'b1, OFS_MASK, 32'hffffffff);
		bus(1'b1, OFS_RXIE, 32'h3);
		for (int f = 0; f < 3; f++) fr($urandom, 8'(8'h40 + 8'(16 * f)));
		rd(OFS_RXFLAG, 32'h3);
		chk({rx_irq, err_irq}, 32'h3);
		rd(10'h070, 32'h4c);
		bus(1'b1, OFS_RXFLAG, 32'h1);
		rd(10'h070, 32'h5c);
		rd(OFS_RXFLAG, 32'h3);
		bus(1'b1, OFS_RXFLAG, 32'h3);
		rd(OFS_RXFLAG, 32'h0);
		for (int b = 0; b < 3; b++) begin
			pr[b] = {6'($urandom), 2'(b)};
			bus(1'b1, 10'h100 + 10'(64 * b), 32'(8'ha0 + 8'(b)));
			bus(1'b1, 10'h134 + 10'(64 * b), 32'(pr[b]));
		end
		best = pr[0] < pr[1] ? (pr[0] < pr[2] ? 2'h0 : 2'h2) : (pr[1] < pr[2] ? 2'h1 : 2'h2);
		bus(1'b1, OFS_TXCTRL, 32'h700);
		bus(1'b1, OFS_TXFLAG, 32'h7);
		rd(OFS_TXFLAG, 32'h0);
		pl(ARB);
		// acknowledge enable is registered after the node turns transmitter
		@(posedge ref_clk);
		chk(eo.ack_en, 32'h0);
		fr($urandom, 8'h0);
		rd(OFS_RXFLAG, 32'h0);
		chk(eo.tx_byte, 32'(8'ha0 + 8'(best)));
		pl(LOST);
		fr(32'h0, 8'h0);
		rd(OFS_RXFLAG, 32'h1);
		bus(1'b1, OFS_RXFLAG, 32'h1);
		pl(ARB);
		pl(ERR);
		pl(ARB);
		chk({eo.tx_valid, eo.tx_sel}, {1'b1, best});
		pl(DONE);
		rd(OFS_TXFLAG, 32'h1 << best);
		chk(tx_irq, 32'h1);
		bus(1'b1, OFS_TXCTRL, 32'h700 | (32'h7 ^ (32'h1 << best)));
		rd(OFS_TXFLAG, 32'h7);
		bus(1'b0, OFS_TXCTRL, 32'h0);
		chk(q & 32'h70, (32'h7 ^ (32'h1 << best)) << 4);
		for (int i = 0; i < 40; i++) begin
			if (i == 20) bus(1'b1, OFS_CTRL, 32'h1);
			t = 1'($urandom);
			th[i] = t;
			dh[i] = 1'($urandom);
			ei.tx_bit <= t;
			node_dom <= dh[i];
			@(posedge ref_clk);
			if (i % 20 > 1) chk(bus_tx_pin, 32'((i > 20) | pv));
			// wired bus seen back two stages later, own pin in loop-back
			if (i % 20 > 3) chk(eo.rx_bit, 32'((i > 20) | (th[i - 3] & ~dh[i - 2])));
			pv = t;
		end
		bus(1'b1, OFS_TXFLAG, 32'h1);
		pl(ARB);
		fr(32'h0, 8'h0);
		rd(OFS_RXFLAG, 32'h1);
		final_report();
	end
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
endmodule // tb_cmb_message_buffer_filter
`default_nettype wire

//--- verilog/cmb_message_buffer_filter.sv
// receive fifo, transmit buffers and identifier filter of the CAN controller
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cmb_message_buffer_filter (
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic [9:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output var  logic [31:0]           avs_readdata,
	output var  logic                  avs_waitrequest,
	input  wire cmb_pkg::cmb_eng_in_s  eng_in,
	output var  cmb_pkg::cmb_eng_out_s eng_out,
	input  wire logic                  bus_rx_pin,
	output var  logic                  bus_tx_pin,
	output var  logic                  rx_irq,
	output var  logic                  tx_irq,
	output var  logic                  err_irq
);
	import cmb_pkg::*;

	cmb_state_s s;
	cmb_state_s next_s;

	// masked byte compare, mask one is don't care
	function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat, input logic [7:0] msk);
		byte_match = &(~(id ^ pat) | msk); // RULE17 RULE26
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	logic [3:0] qhit;
	logic       id1_hit;
	logic       id2_hit;
	logic       id3_hit;
	logic       dual1_hit;
	logic [3:0] fhit;
	logic       accept;
	logic [1:0] hit_idx;
	logic       bg;
	logic       own;
	logic       drop_now;
	logic       wr;
	logic [31:0] rd;
	logic [3:0] widx;
	logic [1:0] wbuf;
	logic [2:0] cand;
	logic       best_ok;
	logic [1:0] best;
	logic       rx_win;
	logic       tx_win;

	assign avs_readdata    = s.rdata;
	assign avs_waitrequest = s.waitreq;
	assign eng_out         = s.eo;
	assign bus_tx_pin      = s.tx_pin;
	assign rx_irq          = s.rx_irq;
	assign tx_irq          = s.tx_irq;
	assign err_irq         = s.err_irq;

	// acceptance compare on the captured identifier bytes
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			qhit[k] = byte_match(s.rx_id[0], s.patt[k], s.mask[k]);
		end
		id1_hit   = byte_match(s.rx_id[1], s.patt[1], s.mask[1]);
		id2_hit   = byte_match(s.rx_id[2], s.patt[2], s.mask[2]);
		id3_hit   = byte_match(s.rx_id[3], s.patt[3], s.mask[3]);
		dual1_hit = byte_match(s.rx_id[1], s.patt[3], s.mask[3]);
		unique case (s.mode) // RULE25
			MODE_SINGLE: fhit = {3'h0, qhit[0] & id1_hit & id2_hit & id3_hit}; // RULE19
			MODE_DUAL:   fhit = {2'h0, qhit[2] & dual1_hit, qhit[0] & id1_hit}; // RULE20
			MODE_QUAD:   fhit = qhit; // RULE21
			MODE_CLOSED: fhit = 4'h0; // RULE22
		endcase
		accept  = |fhit;
		hit_idx = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (fhit[k]) begin
				hit_idx = 2'(k); // RULE18
			end
		end
	end

	// lowest priority value among scheduled buffers, lower index on a tie
	always_comb begin
		cand    = ~s.tx_empty;
		best_ok = 1'b0;
		best    = 2'h0;
		for (int b = 0; b < TX_BUFS; b++) begin
			if (cand[b] && (!best_ok || s.txb[b][LOCAL_PRIORITY_FIELD_SLOT] < s.txb[best][LOCAL_PRIORITY_FIELD_SLOT])) begin
				best_ok = 1'b1; // RULE15
				best    = 2'(b);
			end
		end
	end

	always_comb begin
		next_s   = s;
		bg       = ~s.fg_sel;
		own      = s.tx_active & ~s.loopback; // RULE8 RULE9
		wr       = avs_write & ~s.waitreq;
		widx     = avs_address[5:2];
		wbuf     = avs_address[7:6];
		rx_win   = (avs_address[9:6] == RXWIN_PAGE) && (widx < 4'(MSG_BYTES));
		tx_win   = (avs_address[9:8] == TXWIN_PAGE) && (wbuf < 2'(TX_BUFS)) && (widx <= 4'(LOCAL_PRIORITY_FIELD_SLOT));
		drop_now = (eng_in.rx_idx == 4'h0) ? s.bg_full : s.rx_drop;

		// background fill runs regardless of the filter
		if (eng_in.rx_we) begin
			next_s.rx_drop = drop_now;
			if (!drop_now && eng_in.rx_idx < 4'(MSG_BYTES)) begin
				next_s.rxb[bg][eng_in.rx_idx] = eng_in.rx_data; // RULE1 RULE2 RULE4 RULE7
			end
			if (eng_in.rx_idx < 4'h4) begin
				next_s.rx_id[eng_in.rx_idx[1:0]] = eng_in.rx_data; // RULE4
			end
		end

		// software register writes
		if (wr && avs_address == OFS_CTRL && avs_byteenable[0]) begin
			next_s.loopback = avs_writedata[CTRL_LOOP_BIT];
			next_s.mode     = cmb_mode_e'(avs_writedata[CTRL_MODE_LSB +: 2]);
		end
		if (wr && avs_address == OFS_RXIE && avs_byteenable[0]) begin
			next_s.rx_ie = avs_writedata[1:0];
		end
		if (wr && avs_address == OFS_RXFLAG && avs_byteenable[0]) begin
			if (avs_writedata[RX_FULL_BIT] && s.receive_full_flag) begin // RULE6 RULE24
				if (s.bg_full) begin
					// pending message moves up, flag stays set
					next_s.fg_sel  = ~s.fg_sel; // RULE1
					next_s.bg_full = 1'b0;
					next_s.hit     = s.bg_hit;
				end else begin
					next_s.receive_full_flag = 1'b0;
				end
			end
			if (avs_writedata[RX_OVR_BIT]) begin
				next_s.ovr = 1'b0; // RULE24
			end
		end
		if (wr && avs_address == OFS_TXFLAG && avs_byteenable[0]) begin
			for (int b = 0; b < TX_BUFS; b++) begin
				if (avs_writedata[b] && s.tx_empty[b]) begin
					next_s.tx_empty[b] = 1'b0; // RULE13 RULE24
					next_s.abak[b]     = 1'b0;
				end
			end
		end
		if (wr && avs_address == OFS_TXCTRL) begin
			if (avs_byteenable[0]) begin
				next_s.abrq = s.abrq | avs_writedata[TX_ABRQ_LSB +: 3];
			end
			if (avs_byteenable[1]) begin
				next_s.tx_ie = avs_writedata[TX_IE_LSB +: 3];
			end
		end
		if (wr && avs_address == OFS_PATTERN) begin
			next_s.patt = merge(s.patt, avs_writedata, avs_byteenable); // RULE17
		end
		if (wr && avs_address == OFS_MASK) begin
			next_s.mask = merge(s.mask, avs_writedata, avs_byteenable); // RULE17
		end
		// a buffer under transmission or scheduled is write protected
		if (wr && tx_win && avs_byteenable[0] && s.tx_empty[wbuf]) begin
			next_s.txb[wbuf][widx] = avs_writedata[7:0]; // RULE12
		end

		// end of a correctly received frame, hardware set wins over clear
		if (eng_in.rx_ok && !own && accept) begin // RULE3 RULE8 RULE9 RULE22
			if (s.rx_drop) begin
				next_s.ovr = 1'b1; // RULE11
			end else if (!next_s.receive_full_flag) begin
				next_s.fg_sel = ~s.fg_sel; // RULE5
				next_s.receive_full_flag    = 1'b1; // RULE5
				next_s.hit    = hit_idx; // RULE18
			end else begin
				next_s.bg_full = 1'b1; // RULE11
				next_s.bg_hit  = hit_idx;
			end
		end

		// transmit sequencing
		if (eng_in.arb_req && best_ok) begin
			next_s.tx_active = 1'b1; // RULE15
			next_s.cur       = best;
		end
		if (s.tx_active && (eng_in.tx_lost || eng_in.tx_err)) begin
			next_s.tx_active = 1'b0; // RULE10
		end
		if (s.tx_active && eng_in.tx_done) begin
			next_s.tx_active     = 1'b0;
			next_s.tx_empty[s.cur] = 1'b1; // RULE14
			next_s.abak[s.cur]   = 1'b0; // RULE16
			next_s.abrq[s.cur]   = 1'b0;
		end
		for (int b = 0; b < TX_BUFS; b++) begin
			if (s.abrq[b]) begin
				if (s.tx_empty[b]) begin
					next_s.abrq[b] = 1'b0;
				end else if (!(s.tx_active && s.cur == 2'(b)) && !(eng_in.arb_req && best_ok && best == 2'(b))) begin
					next_s.tx_empty[b] = 1'b1; // RULE16
					next_s.abak[b]     = 1'b1; // RULE16
					next_s.abrq[b]     = 1'b0;
				end
			end
		end

		// engine side outputs
		next_s.eo.tx_valid = best_ok;
		next_s.eo.tx_sel   = best;
		next_s.eo.tx_byte  = (eng_in.tx_idx < 4'(MSG_BYTES)) ? s.txb[s.cur][eng_in.tx_idx] : 8'h00;
		next_s.eo.ack_en   = ~own; // RULE8
		next_s.eo.rx_bit   = s.loopback ? s.tx_pin : bus_rx_pin; // RULE9
		// loop-back keeps the bus recessive
		next_s.tx_pin      = s.loopback ? 1'b1 : eng_in.tx_bit; // RULE23

		next_s.rx_irq  = next_s.receive_full_flag & next_s.rx_ie[RX_FULL_BIT]; // RULE5
		next_s.err_irq = next_s.ovr & next_s.rx_ie[RX_OVR_BIT]; // RULE11
		next_s.tx_irq  = |(next_s.tx_empty & next_s.tx_ie); // RULE14 RULE16

		// read mux
		rd = 32'h0;
		if (avs_address == OFS_CTRL) begin
			rd[CTRL_LOOP_BIT]      = s.loopback;
			rd[CTRL_MODE_LSB +: 2] = s.mode;
		end else if (avs_address == OFS_RXFLAG) begin
			rd[RX_FULL_BIT] = s.receive_full_flag;
			rd[RX_OVR_BIT]  = s.ovr;
		end else if (avs_address == OFS_RXIE) begin
			rd[1:0] = s.rx_ie;
		end else if (avs_address == OFS_TXFLAG) begin
			rd[2:0] = s.tx_empty;
		end else if (avs_address == OFS_TXCTRL) begin
			rd[TX_ABRQ_LSB +: 3] = s.abrq;
			rd[TX_ABAK_LSB +: 3] = s.abak;
			rd[TX_IE_LSB +: 3]   = s.tx_ie;
		end else if (avs_address == OFS_HIT) begin
			rd[1:0] = s.hit;
		end else if (avs_address == OFS_PATTERN) begin
			rd = s.patt;
		end else if (avs_address == OFS_MASK) begin
			rd = s.mask;
		end else if (rx_win) begin
			rd[7:0] = s.rxb[s.fg_sel][widx]; // RULE1
		end else if (tx_win) begin
			rd[7:0] = s.txb[wbuf][widx];
		end

		// one cycle answer, then waitrequest rises again
		if ((avs_read || avs_write) && s.waitreq) begin
			next_s.waitreq = 1'b0;
			next_s.rdata   = avs_read ? rd : 32'h0;
		end else begin
			next_s.waitreq = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s          <= '0;
			s.tx_empty <= RST_TX_EMPTY;
			s.waitreq  <= 1'b1;
			s.tx_pin   <= 1'b1;
			s.eo.ack_en <= 1'b1;
			s.eo.rx_bit <= 1'b1;
		end else if (clk_en) begin
			s <= next_s;
		end
	end
endmodule // cmb_message_buffer_filter
`default_nettype wire

//--- verilog/cmb_pkg.sv
// package of constants and types for the CAN message buffer and filter
// Operation
// RULE1 - two receive buffers swapped ping-pong
// RULE2 - each receive buffer holds thirteen bytes
// RULE3 - receive-full only for good accepted message
// RULE4 - filter and background fill run together
// RULE5 - accepted message swapped to foreground if free
// RULE6 - software reads foreground then clears flag
// RULE7 - next frame fills background right away
// RULE8 - own frame never reaches foreground, no ack
// RULE9 - loop-back treats own frames as received
// RULE10 - lost arbitration turns node into receiver
// RULE11 - both full: drop message, flag overrun
// RULE12 - three transmit buffers, each with priority
// RULE13 - software loads buffer then clears empty
// RULE14 - sent buffer sets empty, transmit interrupt
// RULE15 - lowest priority value wins every arbitration
// RULE16 - abort unsent buffer, set acknowledge, empty
// RULE17 - pattern bits each excludable by mask
// RULE18 - hit field reports lowest matching filter
// RULE19 - single mode: one 32-bit filter
// RULE20 - dual mode: two 16-bit filters
// RULE21 - quad mode: four 8-bit filters
// RULE22 - closed mode accepts nothing
// RULE23 - transmit pin: 0 dominant, 1 recessive
// RULE24 - flags cleared by writing one
// RULE25 - mode field: single, dual, quad, closed
// RULE26 - mask bit one means don't care
package cmb_pkg;
	localparam int unsigned MSG_BYTES = 13;
	localparam int unsigned TX_BUFS   = 3;
	localparam int unsigned LOCAL_PRIORITY_FIELD_SLOT = 13;

	localparam logic [9:0] OFS_CTRL    = 10'h000;
	localparam logic [9:0] OFS_RXFLAG  = 10'h004;
	localparam logic [9:0] OFS_RXIE    = 10'h008;
	localparam logic [9:0] OFS_TXFLAG  = 10'h00c;
	localparam logic [9:0] OFS_TXCTRL  = 10'h010;
	localparam logic [9:0] OFS_HIT     = 10'h014;
	localparam logic [9:0] OFS_PATTERN = 10'h018;
	localparam logic [9:0] OFS_MASK    = 10'h01c;
	localparam logic [3:0] RXWIN_PAGE  = 4'h1;
	localparam logic [1:0] TXWIN_PAGE  = 2'h1;

	localparam int CTRL_LOOP_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int RX_FULL_BIT   = 0;
	localparam int RX_OVR_BIT    = 1;
	localparam int TX_ABRQ_LSB   = 0;
	localparam int TX_ABAK_LSB   = 4;
	localparam int TX_IE_LSB     = 8;

	localparam logic [2:0] RST_TX_EMPTY = 3'h7;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_DUAL   = 2'h1,
		MODE_QUAD   = 2'h2,
		MODE_CLOSED = 2'h3
	} cmb_mode_e;

	typedef struct packed {
		logic       rx_we;
		logic [3:0] rx_idx;
		logic [7:0] rx_data;
		logic       rx_ok;
		logic       arb_req;
		logic       tx_done;
		logic       tx_lost;
		logic       tx_err;
		logic [3:0] tx_idx;
		logic       tx_bit;
	} cmb_eng_in_s;

	typedef struct packed {
		logic       tx_valid;
		logic [1:0] tx_sel;
		logic [7:0] tx_byte;
		logic       ack_en;
		logic       rx_bit;
	} cmb_eng_out_s;

	typedef struct packed {
		logic [1:0][12:0][7:0] rxb;
		logic                  fg_sel;
		logic                  bg_full;
		logic [1:0]            bg_hit;
		logic                  rx_drop;
		logic [3:0][7:0]       rx_id;
		logic [2:0][13:0][7:0] txb;
		logic                  receive_full_flag;
		logic                  ovr;
		logic [1:0]            rx_ie;
		logic                  loopback;
		cmb_mode_e             mode;
		logic [1:0]            hit;
		logic [3:0][7:0]       patt;
		logic [3:0][7:0]       mask;
		logic [2:0]            tx_empty;
		logic [2:0]            abrq;
		logic [2:0]            abak;
		logic [2:0]            tx_ie;
		logic                  tx_active;
		logic [1:0]            cur;
		cmb_eng_out_s          eo;
		logic                  tx_pin;
		logic                  rx_irq;
		logic                  tx_irq;
		logic                  err_irq;
		logic                  waitreq;
		logic [31:0]           rdata;
	} cmb_state_s;
endpackage
